// >>> pkg/led_dim_pkg.sv
// Shared constants and types for the LED dimming and sync control link
package led_dim_pkg;
    localparam int CLK_MHZ = 25;
    localparam int SYNC_LOW_NS = 7000;
    localparam int SYNC_LOW_CYC = (SYNC_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int LOWPWR_CYC = 32750;
    localparam int SWITCH_GAP_NS = 500;
    localparam int SWITCH_GAP_CYC = (SWITCH_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int DIM_DELAY_NS = 500;
    localparam int DIM_DELAY_CYC = (DIM_DELAY_NS * CLK_MHZ) / 1000;
    localparam int SETTLE_CYC = 75000;
    localparam int TRIM_WIDTH = 8;
    localparam int SOFTSTART_CYC = 64;
    localparam int CH_NUM = 2;
    typedef enum logic [2:0] {ST_OFF, ST_SOFT, ST_RUN, ST_SHUT, ST_LOWPWR} dev_state_e;
endpackage

// >>> pkg/led_dim_if.sv
// Pin-level link between host controller and LED driver control
`timescale 1ns/1ps
interface led_dim_if;
    logic dim_enable;
    logic freq_set_sync_pin;
    logic current_trim_duty_input;
    modport device (input dim_enable, input freq_set_sync_pin, input current_trim_duty_input);
    modport host (output dim_enable, output freq_set_sync_pin, output current_trim_duty_input);
endinterface

// >>> verilog/led_dim_device.sv
// Device end: dimming, sync-low shutdown, low-power entry and current trim
`timescale 1ns/1ps
module led_dim_device
    import led_dim_pkg::*;
#(
    parameter int LOWPWR_CYCLES = LOWPWR_CYC,
    parameter int SETTLE_CYCLES = SETTLE_CYC,
    parameter int SOFT_CYCLES = SOFTSTART_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link
    led_dim_if.device link,
    // User side
    input wire logic sync_guard_i,
    input wire logic [CH_NUM-1:0] ch_enable_i,
    // Power stage
    output logic boost_on_o,
    output logic disconnect_closed_o,
    output logic [CH_NUM-1:0] sink_on_o,
    output logic comp_float_o,
    // Status
    output logic low_power_o,
    output logic soft_start_o,
    output logic shutdown_o,
    output logic ext_sync_o,
    output logic fault_o,
    // Trim level
    output logic [TRIM_WIDTH-1:0] current_level_o
);
    typedef struct packed {
        // Pin synchronisers
        logic [1:0] dim_sy;
        logic [1:0] sync_sy;
        logic [1:0] trim_sy;
        logic sync_prev;
        // Control state and timers
        dev_state_e st;
        logic [15:0] low_cnt;
        logic [15:0] sync_cnt;
        logic [15:0] soft_cnt;
        // Trim measurement and level
        logic [TRIM_WIDTH-1:0] win_cnt;
        logic [TRIM_WIDTH-1:0] high_cnt;
        logic [TRIM_WIDTH-1:0] target;
        logic [TRIM_WIDTH-1:0] level;
        logic [16:0] settle_cnt;
        // Registered outputs
        logic ext_sync;
        logic [CH_NUM-1:0] sink;
        logic boost;
        logic disc;
    } dev_s;

    dev_s s_r;
    dev_s s_nxt;
    // Pin levels after the second synchroniser stage, plus the run decode
    logic dim;
    logic sync;
    logic trim;
    logic run;

    // Level step spacing, so a full-scale sweep spans the settle time
    localparam logic [16:0] STEP_LIMIT = 17'(SETTLE_CYCLES / (2 ** TRIM_WIDTH));

    assign dim = s_r.dim_sy[1];
    assign sync = s_r.sync_sy[1];
    assign trim = s_r.trim_sy[1];

    // Next state: one pass over the whole state record
    always_comb begin
        s_nxt = s_r;
        s_nxt.dim_sy = {s_r.dim_sy[0], link.dim_enable};
        s_nxt.sync_sy = {s_r.sync_sy[0], link.freq_set_sync_pin};
        s_nxt.trim_sy = {s_r.trim_sy[0], link.current_trim_duty_input};
        s_nxt.sync_prev = sync;

        // Sync low time; guarded low is treated as internal clock
        if (sync || sync_guard_i) begin
            s_nxt.sync_cnt = '0;
        end else if (s_r.sync_cnt < 16'(SYNC_LOW_CYC)) begin
            s_nxt.sync_cnt = s_r.sync_cnt + 16'h0001;
        end

        // Edge seen recently marks external sync in use
        if (sync && !s_r.sync_prev) begin
            s_nxt.ext_sync = 1'b1;
        end else if (s_r.sync_cnt != '0 || sync_guard_i) begin
            s_nxt.ext_sync = 1'b0;
        end

        // Low-power timer saturates, so the state checks keep seeing it
        if (dim) begin
            s_nxt.low_cnt = '0;
        end else if (s_r.low_cnt < 16'(LOWPWR_CYCLES)) begin
            s_nxt.low_cnt = s_r.low_cnt + 16'h0001;
        end

        // Operating state
        case (s_r.st)
            ST_OFF: begin
                // A sync pin held low blocks power-up
                if (dim && sync) begin
                    s_nxt.st = ST_SOFT;
                    s_nxt.soft_cnt = '0;
                end else if (s_r.low_cnt >= 16'(LOWPWR_CYCLES)) begin
                    s_nxt.st = ST_LOWPWR;
                end
            end
            ST_SOFT: begin
                // Fixed count stands in for the analog ramp
                s_nxt.soft_cnt = s_r.soft_cnt + 16'h0001;
                if (s_r.soft_cnt >= 16'(SOFT_CYCLES)) begin
                    s_nxt.st = ST_RUN;
                end
            end
            ST_RUN: begin
                // Long enable-low period drops to low power
                if (s_r.low_cnt >= 16'(LOWPWR_CYCLES)) begin
                    s_nxt.st = ST_LOWPWR;
                end
            end
            ST_SHUT: begin
                // Release after the low period restarts via soft start
                if (sync) begin
                    s_nxt.st = ST_SOFT;
                    s_nxt.soft_cnt = '0;
                end
            end
            ST_LOWPWR: begin
                // Only enable with a live sync pin wakes it
                if (dim && sync) begin
                    s_nxt.st = ST_SOFT;
                    s_nxt.soft_cnt = '0;
                end
            end
            default: begin
                s_nxt.st = ST_OFF;
            end
        endcase

        // Sync stuck low wins over every other state except low power
        if (s_r.sync_cnt >= 16'(SYNC_LOW_CYC) && s_r.st != ST_LOWPWR) begin
            s_nxt.st = ST_SHUT;
        end

        // Trim duty measured over a fixed window of samples
        s_nxt.win_cnt = s_r.win_cnt + 1'b1;
        // Window edge: take inverted count, restart with this sample
        if (s_r.win_cnt == '1) begin
            s_nxt.high_cnt = TRIM_WIDTH'(trim);
            s_nxt.target = ~s_r.high_cnt;
        end else if (trim && s_r.high_cnt != '1) begin
            s_nxt.high_cnt = s_r.high_cnt + 1'b1;
        end

        // Level moves one step every STEP_LIMIT + 1 cycles, giving slow response
        if (s_r.settle_cnt >= STEP_LIMIT) begin
            s_nxt.settle_cnt = '0;
            if (s_r.level < s_r.target) begin
                s_nxt.level = s_r.level + 1'b1;
            end else if (s_r.level > s_r.target) begin
                s_nxt.level = s_r.level - 1'b1;
            end
        end else begin
            s_nxt.settle_cnt = s_r.settle_cnt + 17'h00001;
        end

        // Outputs follow one cycle after sync stage, far under 500 ns
        run = (s_nxt.st == ST_SOFT || s_nxt.st == ST_RUN);
        s_nxt.boost = run && dim;
        s_nxt.sink = (run && dim) ? ch_enable_i : '0;
        s_nxt.disc = run || s_nxt.st == ST_OFF;
    end

    // Single state register, asynchronous reset to idle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Sync stages start at the pin's idle high, so no false edge follows reset
            s_r <= '{st: ST_OFF, level: '1, target: '1, sync_sy: 2'h3, sync_prev: 1'h1,
                     default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Power stage
    assign boost_on_o = s_r.boost;
    assign disconnect_closed_o = s_r.disc;
    // One sink gate per channel
    for (genvar ch = 0; ch < CH_NUM; ch++) begin : g_sink
        assign sink_on_o[ch] = s_r.sink[ch];
    end
    assign comp_float_o = !s_r.boost;

    // State flags
    assign low_power_o = (s_r.st == ST_LOWPWR);
    assign soft_start_o = (s_r.st == ST_SOFT);
    assign shutdown_o = (s_r.st == ST_SHUT);

    // Sync and trim status
    assign ext_sync_o = s_r.ext_sync;
    assign fault_o = 1'b0;
    assign current_level_o = s_r.level;
endmodule

// >>> verilog/led_dim_host.sv
// Host end: drives dimming, sync select and trim pins from user requests
`timescale 1ns/1ps
module led_dim_host
    import led_dim_pkg::*;
#(
    parameter int DIM_PERIOD = 50000,
    parameter int TRIM_PERIOD = 256
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link
    led_dim_if.host link,
    // User side
    input wire logic [15:0] dim_high_i,
    input wire logic [7:0] trim_high_i,
    input wire logic use_ext_sync_i,
    input wire logic ext_sync_clk_i,
    input wire logic hold_sync_low_i,
    output logic sync_is_ext_o
);
    typedef struct packed {
        logic [15:0] dim_cnt;
        logic [8:0] trim_cnt;
        logic [15:0] since_rise;
        logic sel_ext;
        logic dim;
        logic trim;
        logic sync;
    } host_s;

    host_s s_r;
    host_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        // Dimming period 2 ms at this clock by default
        s_nxt.dim_cnt = (s_r.dim_cnt >= 16'(DIM_PERIOD - 1)) ? '0 : s_r.dim_cnt + 16'h0001;
        s_nxt.dim = s_nxt.dim_cnt < dim_high_i;
        s_nxt.trim_cnt = (s_r.trim_cnt >= 9'(TRIM_PERIOD - 1)) ? '0 : s_r.trim_cnt + 9'h001;
        s_nxt.trim = s_nxt.trim_cnt < {1'b0, trim_high_i};
        if (s_nxt.dim && !s_r.dim) begin
            s_nxt.since_rise = '0;
        end else if (s_r.since_rise != '1) begin
            s_nxt.since_rise = s_r.since_rise + 16'h0001;
        end
        // Changeover only while dimming low or well after its rise
        if (!s_r.dim || s_r.since_rise >= 16'(SWITCH_GAP_CYC)) begin
            s_nxt.sel_ext = use_ext_sync_i;
        end
        s_nxt.sync = hold_sync_low_i ? 1'b0 : (s_r.sel_ext ? ext_sync_clk_i : 1'b1);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '{since_rise: '1, sync: 1'b1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.dim_enable = s_r.dim;
    assign link.current_trim_duty_input = s_r.trim;
    assign link.freq_set_sync_pin = s_r.sync;
    assign sync_is_ext_o = s_r.sel_ext;
endmodule

// >>> test/led_dim_properties.sv
// Checks on the dimming link pins and the device end outputs
`timescale 1ns/1ps
module led_dim_properties
    import led_dim_pkg::*;
#(
    parameter int LOWPWR_CYCLES = 100
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link and user side
    input wire logic dim_enable,
    input wire logic freq_set_sync_pin,
    input wire logic sync_guard_i,
    input wire logic [CH_NUM-1:0] ch_enable_i,
    // Device outputs
    input wire logic boost_on_o,
    input wire logic disconnect_closed_o,
    input wire logic [CH_NUM-1:0] sink_on_o,
    input wire logic comp_float_o,
    input wire logic low_power_o,
    input wire logic soft_start_o,
    input wire logic shutdown_o,
    input wire logic fault_o,
    input wire logic [TRIM_WIDTH-1:0] current_level_o
);
    // Saturating run lengths of low pin levels
    logic [15:0] dim_lo_r;
    logic [15:0] sync_lo_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dim_lo_r <= 16'h0000;
            sync_lo_r <= 16'h0000;
        end else begin
            dim_lo_r <= dim_enable ? 16'h0000 : dim_lo_r + {15'h0, ~&dim_lo_r};
            sync_lo_r <= (freq_set_sync_pin || sync_guard_i) ? 16'h0000 : sync_lo_r + {15'h0, ~&sync_lo_r};
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence lvl_hold;
        $stable(current_level_o) [*8];
    endsequence
    // Latency window of two to four edges covered
    chk_dark_when_off: assert property (
        !$past(dim_enable, 2) && !$past(dim_enable, 3) && !$past(dim_enable, 4)
        |-> !boost_on_o && comp_float_o && sink_on_o == '0) else $error("Output on while dim low");
    chk_float_follows: assert property (
        comp_float_o == !boost_on_o) else $error("Comp float mismatch");
    chk_sink_full: assert property (
        boost_on_o && $stable(ch_enable_i) |-> sink_on_o == ch_enable_i) else $error("Sinks not full");
    chk_boost_cause: assert property (
        $rose(boost_on_o) |-> $past(dim_enable, 2) || $past(dim_enable, 3)) else $error("Boost without dim");
    chk_shut_dark: assert property (
        shutdown_o |-> !boost_on_o && !disconnect_closed_o && sink_on_o == '0) else $error("Shutdown leaks");
    chk_sync_shut: assert property (
        sync_lo_r == 16'h00B9 && !low_power_o |-> shutdown_o) else $error("No shutdown on sync low");
    chk_guard_run: assert property (
        sync_guard_i && $past(sync_guard_i, 3) && !$past(shutdown_o) |-> !shutdown_o) else $error("Guarded shutdown");
    chk_no_fault: assert property (
        !fault_o) else $error("Fault raised");
    chk_soft_restart: assert property (
        $fell(shutdown_o) |-> soft_start_o) else $error("No soft start after shutdown");
    chk_lp_entry: assert property (
        $rose(low_power_o) |-> dim_lo_r >= 16'(LOWPWR_CYCLES)) else $error("Early low power");
    chk_lp_late: assert property (
        dim_lo_r == 16'(LOWPWR_CYCLES + 8) && !shutdown_o |-> low_power_o) else $error("Low power missed");
    chk_trim_pace: assert property (
        $changed(current_level_o) |=> lvl_hold) else $error("Trim level steps too fast");
endmodule

// >>> test/tb_top.sv
// Self-checking bench joining host and device ends
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] dim_high_i = 16'h0000;
    logic [7:0] trim_high_i = 8'h00;
    logic use_ext_sync_i = 1'b0;
    logic ext_sync_clk_i = 1'b0;
    logic hold_sync_low_i = 1'b0;
    logic sync_guard_i = 1'b0;
    logic [1:0] ch_enable_i = 2'h3;
    logic boost_on_o, disconnect_closed_o, comp_float_o, low_power_o;
    logic soft_start_o, shutdown_o, ext_sync_o, fault_o, sync_is_ext_o;
    logic [1:0] sink_on_o;
    logic [7:0] current_level_o;
    int err_count = 0;
    int n_compared = 0;
    // Channel enables, trim high count, settled level
    logic [19:0] rows [4] = '{20'h300FF, 20'h140BF, 20'h2807F, 20'h320DF};
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) ext_sync_clk_i <= ~ext_sync_clk_i;
    led_dim_if led_dim_if_i ();
    led_dim_host #(.DIM_PERIOD(200)) led_dim_host_i (.clk_i(clk_i), .rst_i(rst_i),
        .link(led_dim_if_i), .dim_high_i(dim_high_i), .trim_high_i(trim_high_i), .use_ext_sync_i(use_ext_sync_i),
        .ext_sync_clk_i(ext_sync_clk_i), .hold_sync_low_i(hold_sync_low_i), .sync_is_ext_o(sync_is_ext_o));
    led_dim_device #(.LOWPWR_CYCLES(100), .SETTLE_CYCLES(2560), .SOFT_CYCLES(8)) led_dim_device_i (.clk_i(clk_i),
        .rst_i(rst_i), .link(led_dim_if_i), .sync_guard_i(sync_guard_i), .ch_enable_i(ch_enable_i),
        .boost_on_o(boost_on_o), .disconnect_closed_o(disconnect_closed_o), .sink_on_o(sink_on_o),
        .comp_float_o(comp_float_o), .low_power_o(low_power_o), .soft_start_o(soft_start_o),
        .shutdown_o(shutdown_o), .ext_sync_o(ext_sync_o), .fault_o(fault_o), .current_level_o(current_level_o));
    led_dim_properties #(.LOWPWR_CYCLES(100)) led_dim_properties_i (.clk_i(clk_i), .rst_i(rst_i),
        .dim_enable(led_dim_if_i.dim_enable), .freq_set_sync_pin(led_dim_if_i.freq_set_sync_pin),
        .sync_guard_i(sync_guard_i), .ch_enable_i(ch_enable_i), .boost_on_o(boost_on_o),
        .disconnect_closed_o(disconnect_closed_o), .sink_on_o(sink_on_o), .comp_float_o(comp_float_o),
        .low_power_o(low_power_o), .soft_start_o(soft_start_o), .shutdown_o(shutdown_o), .fault_o(fault_o),
        .current_level_o(current_level_o));
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic cmp_b(input logic g, input logic e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmp_v(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic complete_run();
        if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        step(2);
        rst_i <= 1'b0;
        dim_high_i <= 16'hFFFF;
        step(40);
        #1 cmp_b(boost_on_o, 1'b1);
        cmp_b(ext_sync_o, 1'b0);
        for (int i = 0; i < 4; i++) begin
            step(1);
            ch_enable_i <= rows[i][17:16];
            trim_high_i <= rows[i][15:8];
            step(2000);
            #1 cmp_v(current_level_o, rows[i][7:0]);
            cmp_v({6'h00, sink_on_o}, {6'h00, rows[i][17:16]});
        end
        step(1);
        dim_high_i <= 16'h0000;
        use_ext_sync_i <= 1'b1;
        step(20);
        dim_high_i <= 16'hFFFF;
        step(40);
        #1 cmp_b(sync_is_ext_o, 1'b1);
        cmp_b(ext_sync_o, 1'b1);
        step(1);
        dim_high_i <= 16'h0000;
        step(20);
        dim_high_i <= 16'hFFFF;
        step(2);
        use_ext_sync_i <= 1'b0;
        step(5);
        #1 cmp_b(sync_is_ext_o, 1'b1);
        step(20);
        #1 cmp_b(sync_is_ext_o, 1'b0);
        step(1);
        sync_guard_i <= 1'b1;
        hold_sync_low_i <= 1'b1;
        step(300);
        #1 cmp_b(shutdown_o, 1'b0);
        cmp_b(boost_on_o, 1'b1);
        cmp_b(ext_sync_o, 1'b0);
        step(1);
        sync_guard_i <= 1'b0;
        hold_sync_low_i <= 1'b0;
        step(10);
        hold_sync_low_i <= 1'b1;
        step(150);
        #1 cmp_b(shutdown_o, 1'b0);
        step(50);
        #1 cmp_b(shutdown_o, 1'b1);
        cmp_b(disconnect_closed_o, 1'b0);
        step(1);
        hold_sync_low_i <= 1'b0;
        step(6);
        #1 cmp_b(soft_start_o, 1'b1);
        step(1);
        dim_high_i <= 16'h0096;
        step(600);
        #1 cmp_b(low_power_o, 1'b0);
        step(1);
        dim_high_i <= 16'hFFFF;
        step(10);
        dim_high_i <= 16'h0000;
        step(80);
        #1 cmp_b(low_power_o, 1'b0);
        step(40);
        #1 cmp_b(low_power_o, 1'b1);
        step(1);
        dim_high_i <= 16'hFFFF;
        rst_i <= 1'b1;
        step(2);
        #1 cmp_v(current_level_o, 8'hFF);
        step(1);
        rst_i <= 1'b0;
        step(40);
        #1 cmp_b(boost_on_o, 1'b1);
        cmp_b(ext_sync_o, 1'b0);
        complete_run();
    end
    // Expected run is near 10000 cycles
    initial begin
        repeat (40000) @(posedge clk_i);
        err_count++;
        complete_run();
    end
endmodule
